// ===== verilog/sleep_seq_regs.svh
// Register offsets, field positions, reset values and timing counts of the sleep sequencer
`ifndef SLEEP_SEQ_REGS_SVH
`define SLEEP_SEQ_REGS_SVH

// Register byte offsets
`define CTRL_OFS 8'h00
`define CORE_PSTATE_OFS 8'h04
`define STATUS_OFS 8'h08

// Control field positions and reset values
`define CTRL_CXE_BIT 0
`define CTRL_FORCED_BIT 1
`define CTRL_THERM_LSB 4
`define CORE_PSTATE_STRIDE 4
`define CTRL_RESET 32'h0000_0001
`define CORE_PSTATE_RESET 32'h0000_0000

// Timing, clock period in ns
`define CLK_PERIOD_NS 20
`define SG_SETTLE_CYC 8
`define RESET_HOLD_CYC 16
`define PLL_RELOCK_NS 5000
`define VID_STEP_NS 200
`define VID_SETTLE_NS 1000
`define THERM_WAIT_US 100
`define XFER_MAX_MS 10

// Voltage codes, a larger code is a lower voltage
`define VID_LOWEST 7'h30
`define VID_PER_PSTATE 7'h04
`define VID_DEEPER 7'h48
`define LOWEST_PSTATE 3'h0

// Bus responses
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ===== verilog/sleep_seq_pkg.sv
// Types shared by the package sleep state sequencer
package sleep_seq_pkg;

  typedef logic [2:0] pstate_t;
  typedef logic [6:0] vid_t;

  // Package low power states
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_CXE_DOWN,
    ST_SG_ENTRY,
    ST_STOP_GRANT,
    ST_SLEEP,
    ST_DEEP,
    ST_DEEPER,
    ST_DEEPER_EXIT
  } pkg_state_e;

  // Phases of one voltage and frequency transition
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_VID_UP,
    PH_RELOCK_UP,
    PH_RELOCK_DN,
    PH_VID_DN
  } step_phase_e;

  // Active low request pins from the chipset
  typedef struct packed {
    logic stop_clock_request_n;
    logic sleep_request_n;
    logic deep_sleep_request_n;
    logic deeper_voltage_request_n;
    logic system_reset_n;
  } lp_pins_s;

endpackage : sleep_seq_pkg

// ===== verilog/pin_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic aclk,
  input logic aresetn,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pin_sync

// ===== verilog/pstate_stepper.sv
// Voltage and frequency transition stepper with snoop blocking
`timescale 1ns/1ps
`include "sleep_seq_regs.svh"
module pstate_stepper #(
  parameter int XFER_MAX_CYCLES = `XFER_MAX_MS * 1000000 / `CLK_PERIOD_NS
) (
  input logic aclk,
  input logic aresetn,
  input logic start,
  input sleep_seq_pkg::pstate_t target,
  output sleep_seq_pkg::pstate_t cur_pstate,
  output sleep_seq_pkg::vid_t vid,
  output logic busy,
  output logic block_next_request_n
);
  import sleep_seq_pkg::*;

  localparam int RELOCK_CYC = (`PLL_RELOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int STEP_CYC = (`VID_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  step_phase_e phase;
  pstate_t tgt;
  logic [15:0] cnt;
  logic [19:0] held_cnt;

  function automatic vid_t vid_of(input pstate_t p);
    vid_of = `VID_LOWEST - `VID_PER_PSTATE * {4'h0, p};
  endfunction : vid_of

  // Step and relock timers share one counter
  wire step_tick = cnt == 16'(STEP_CYC - 1);
  wire relock_done = cnt == 16'(RELOCK_CYC - 1);
  wire relocking = (phase == PH_RELOCK_UP) || (phase == PH_RELOCK_DN);
  assign busy = phase != PH_IDLE;
  assign block_next_request_n = !relocking;

  // Transition sequence; the target is latched so later requests wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase <= PH_IDLE;
      tgt <= `LOWEST_PSTATE;
      cur_pstate <= `LOWEST_PSTATE;
      vid <= `VID_LOWEST;
      cnt <= 16'h0000;
    end
    else
    begin
      case (phase)
        PH_IDLE:
        begin
          cnt <= 16'h0000;
          if (start && target != cur_pstate)
          begin
            tgt <= target;
            phase <= (target > cur_pstate) ? PH_VID_UP : PH_RELOCK_DN;
          end
        end
        PH_VID_UP:
        begin
          if (vid == vid_of(tgt))
          begin
            phase <= PH_RELOCK_UP;
            cnt <= 16'h0000;
          end
          else if (step_tick)
          begin
            vid <= vid - 7'h01;
            cnt <= 16'h0000;
          end
          else
            cnt <= cnt + 16'h0001;
        end
        PH_RELOCK_UP:
        begin
          if (relock_done)
          begin
            cur_pstate <= tgt;
            phase <= PH_IDLE;
          end
          else
            cnt <= cnt + 16'h0001;
        end
        PH_RELOCK_DN:
        begin
          cnt <= relock_done ? 16'h0000 : cnt + 16'h0001;
          if (relock_done)
          begin
            cur_pstate <= tgt;
            phase <= PH_VID_DN;
          end
        end
        PH_VID_DN:
        begin
          if (vid == vid_of(cur_pstate))
            phase <= PH_IDLE;
          else if (step_tick)
          begin
            vid <= vid + 7'h01;
            cnt <= 16'h0000;
          end
          else
            cnt <= cnt + 16'h0001;
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Cycles the cores have been kept off the bus
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      held_cnt <= 20'h00000;
    else
      held_cnt <= relocking ? held_cnt + 20'h00001 : 20'h00000;
  end

  chk_up_vid_first: assert property (@(posedge aclk) disable iff (!aresetn)
    phase == PH_RELOCK_UP |-> vid == vid_of(tgt)) else $error("relock before voltage raised");
  chk_down_relock_first: assert property (@(posedge aclk) disable iff (!aresetn)
    phase == PH_VID_DN |-> cur_pstate == tgt) else $error("voltage lowered before relock");
  chk_deferred_target: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && $past(busy) |-> $stable(tgt)) else $error("running transition retargeted");
  chk_unavail_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    held_cnt < 20'(XFER_MAX_CYCLES)) else $error("cores unavailable too long");

endmodule : pstate_stepper

// ===== verilog/package_sleep_state_sequencer.sv
// Package sleep state sequencer with performance state coordination
// Behaviour
// - Sleep is entered only from Stop-Grant with sleep request; clocks halt, PLL kept. The code also returns to Sleep from Deep Sleep.
// - No snoop answers or interrupt latching while in or entering sleep states.
// - Reset held during a sleep state returns straight to Normal.
// - Deep Sleep is entered only from Sleep on deep-sleep request; the code also enters it from the Deeper Sleep exit once the voltage settles.
// - Deep Sleep ignores snoops and interrupts; bus stays unchanged.
// - Deeper Sleep is entered from Deep Sleep on deeper request.
// - Entering Deeper Sleep drives the Deeper Sleep voltage code.
// - Upward change raises voltage then relocks; downward relocks then lowers.
// - Performance requests are always accepted; later ones wait for the current one.
// - Snoops are blocked during relock, at most 10 ms.
// - A hot die drops to the thermal point, waits, returns; events pulse.
// - Four core requests merge into one package point; equal requests are honoured.
// - With extended states, step to lowest point before Stop-Grant; resume on break.
// - No transitions in sleep states, except forced lowest point after Deeper; the code only blocks new starts there and takes the forced step in Stop-Grant.
// - Stop-Grant is reached within 20 clocks of the acknowledge cycle.
// - Deeper Sleep is requested only when every core is in deepest idle.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sleep_seq_regs.svh"
module package_sleep_state_sequencer #(
  parameter int CORES = 4,
  parameter int THERM_WAIT_CYCLES = `THERM_WAIT_US * 1000 / `CLK_PERIOD_NS,
  parameter int XFER_MAX_CYCLES = `XFER_MAX_MS * 1000000 / `CLK_PERIOD_NS
) (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input sleep_seq_pkg::lp_pins_s lp_pins,
  input logic die_hot,
  input logic [CORES-1:0] core_idle_deepest,
  output logic stop_grant_ack,
  output logic internal_clock_enable,
  output logic pll_keep_locked,
  output logic snoop_irq_enable,
  output logic block_next_request_n,
  output sleep_seq_pkg::vid_t voltage_id_code,
  output logic deeper_request,
  output logic thermal_event,
  output logic core_reset
);
  import sleep_seq_pkg::*;

  localparam int VID_SETTLE_CYC = (`VID_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  lp_pins_s pins;
  logic hot;
  pkg_state_e state;
  pkg_state_e next_state;
  logic [15:0] cnt;
  logic [4:0] rst_cnt;
  logic forced_low;
  logic therm_active;
  logic [15:0] therm_cnt;
  logic [31:0] ctrl_reg;
  logic [31:0] core_pstate_reg;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  pstate_t core_req [CORES];
  pstate_t coord;
  pstate_t cur_pstate;
  vid_t step_vid;
  logic step_busy;

  // Pins and the sensor come from outside this clock
  pin_sync #(
    .W($bits(lp_pins_s) + 1),
    .RST_VAL({{$bits(lp_pins_s){1'b1}}, 1'b0})
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({lp_pins, die_hot}),
    .q({pins, hot})
  );

  // Register bus write path: address and data taken in either order
  wire do_write = aw_got && w_got && !s_axi_bvalid;
  wire wr_ctrl = do_write && aw_addr_q == `CTRL_OFS;
  wire wr_core = do_write && aw_addr_q == `CORE_PSTATE_OFS;
  wire wr_hit = wr_ctrl || wr_core || aw_addr_q == `STATUS_OFS;
  wire rd_ctrl = s_axi_araddr == `CTRL_OFS;
  wire rd_core = s_axi_araddr == `CORE_PSTATE_OFS;
  wire rd_stat = s_axi_araddr == `STATUS_OFS;
  wire rd_hit = rd_ctrl || rd_core || rd_stat;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Byte lane merge under the write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        merge[8*b +: 8] = data[8*b +: 8];
  endfunction : merge

  // Status shows live sequencer state, fields read as zero elsewhere
  wire [31:0] status_word = {14'h0000, therm_active, step_busy, 1'b0, voltage_id_code, 1'b0,
                             cur_pstate, 1'b0, state};
  wire [31:0] rd_word = rd_ctrl ? ctrl_reg : rd_core ? core_pstate_reg : rd_stat ? status_word : 32'h0000_0000;

  // Bus handshakes and register storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
      ctrl_reg <= `CTRL_RESET;
      core_pstate_reg <= `CORE_PSTATE_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        ctrl_reg <= merge(ctrl_reg, w_data_q, w_strb_q) & 32'h0000_0073;
      if (wr_core)
        core_pstate_reg <= merge(core_pstate_reg, w_data_q, w_strb_q) & 32'h0000_7777;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Per-core request fields
  genvar gi;
  generate
    for (gi = 0; gi < CORES; gi++)
    begin : g_core
      assign core_req[gi] = core_pstate_reg[`CORE_PSTATE_STRIDE*gi +: 3];
    end
  endgenerate

  // Highest request wins, so equal requests give their common point
  always_comb
  begin
    coord = core_req[0];
    for (int i = 1; i < CORES; i++)
      if (core_req[i] > coord)
        coord = core_req[i];
  end

  // Target selection: forced lowest beats the thermal cap beats the cores
  wire cxe_en = ctrl_reg[`CTRL_CXE_BIT];
  wire forced_opt = ctrl_reg[`CTRL_FORCED_BIT];
  wire [2:0] therm_pstate = ctrl_reg[`CTRL_THERM_LSB +: 3];
  wire [2:0] limited = (therm_active && therm_pstate < coord) ? therm_pstate : coord;
  wire [2:0] step_target = forced_low ? `LOWEST_PSTATE : limited;
  // Clocks are stopped in the sleep family, so no stepping there
  wire step_start = state inside {ST_NORMAL, ST_CXE_DOWN, ST_SG_ENTRY, ST_STOP_GRANT};

  pstate_stepper #(
    .XFER_MAX_CYCLES(XFER_MAX_CYCLES)
  ) u_stepper (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(step_start),
    .target(step_target),
    .cur_pstate(cur_pstate),
    .vid(step_vid),
    .busy(step_busy),
    .block_next_request_n(block_next_request_n)
  );

  // Package state decode
  wire sleep_family = state inside {ST_SLEEP, ST_DEEP, ST_DEEPER, ST_DEEPER_EXIT};
  wire reset_held = rst_cnt == 5'(`RESET_HOLD_CYC);
  assign internal_clock_enable = !sleep_family;
  assign snoop_irq_enable = !sleep_family && state != ST_SG_ENTRY;
  assign pll_keep_locked = !(state inside {ST_DEEP, ST_DEEPER, ST_DEEPER_EXIT});
  assign core_reset = reset_held;

  // Next package state from the synchronised request pins
  always_comb
  begin
    next_state = state;
    case (state)
      ST_NORMAL:
        if (!pins.stop_clock_request_n)
          next_state = cxe_en ? ST_CXE_DOWN : ST_SG_ENTRY;
      ST_CXE_DOWN:
        if (pins.stop_clock_request_n)
          next_state = ST_NORMAL;
        else if (!step_busy && cur_pstate == `LOWEST_PSTATE)
          next_state = ST_SG_ENTRY;
      ST_SG_ENTRY:
        if (cnt == 16'(`SG_SETTLE_CYC - 1))
          next_state = ST_STOP_GRANT;
      ST_STOP_GRANT:
        if (pins.stop_clock_request_n)
          next_state = ST_NORMAL;
        else if (!pins.sleep_request_n)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (!pins.deep_sleep_request_n)
          next_state = ST_DEEP;
        else if (pins.sleep_request_n)
          next_state = ST_STOP_GRANT;
      ST_DEEP:
        if (!pins.deeper_voltage_request_n)
          next_state = ST_DEEPER;
        else if (pins.deep_sleep_request_n)
          next_state = ST_SLEEP;
      ST_DEEPER:
        if (pins.deeper_voltage_request_n)
          next_state = ST_DEEPER_EXIT;
      ST_DEEPER_EXIT:
        if (cnt == 16'(VID_SETTLE_CYC - 1))
          next_state = ST_DEEP;
      default: next_state = ST_NORMAL;
    endcase
    if (sleep_family && !pins.system_reset_n)
      next_state = reset_held ? ST_NORMAL : state;
  end

  // State, dwell counter, voltage code and acknowledge pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_NORMAL;
      cnt <= 16'h0000;
      voltage_id_code <= `VID_LOWEST;
      stop_grant_ack <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= (next_state != state) ? 16'h0000 : cnt + 16'h0001;
      voltage_id_code <= (next_state == ST_DEEPER) ? `VID_DEEPER : step_vid;
      stop_grant_ack <= next_state == ST_SG_ENTRY && state != ST_SG_ENTRY;
    end
  end

  // Reset pin hold time, forced lowest point and deeper request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_cnt <= 5'h00;
      forced_low <= 1'b0;
      deeper_request <= 1'b0;
    end
    else
    begin
      rst_cnt <= pins.system_reset_n ? 5'h00 : reset_held ? rst_cnt : rst_cnt + 5'h01;
      if (state == ST_NORMAL)
        forced_low <= 1'b0;
      else if (state == ST_CXE_DOWN || (state == ST_DEEPER && forced_opt))
        forced_low <= 1'b1;
      deeper_request <= &core_idle_deepest;
    end
  end

  // Thermal excursion: stay at the cap for a fixed wait, leave once cool
  wire therm_wait_done = therm_cnt == 16'(THERM_WAIT_CYCLES - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      therm_active <= 1'b0;
      therm_cnt <= 16'h0000;
      thermal_event <= 1'b0;
    end
    else
    begin
      thermal_event <= (!therm_active && hot) || (therm_active && therm_wait_done && !hot);
      if (!therm_active)
      begin
        therm_active <= hot;
        therm_cnt <= 16'h0000;
      end
      else if (therm_wait_done)
      begin
        therm_active <= hot;
        therm_cnt <= 16'h0000;
      end
      else
        therm_cnt <= therm_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_sleep_from_grant: assert property ($rose(state == ST_SLEEP) |->
    $past(state) inside {ST_STOP_GRANT, ST_DEEP}) else $error("sleep entered from wrong state");
  chk_clock_halt_sleep: assert property (state == ST_SLEEP |-> !internal_clock_enable &&
    pll_keep_locked) else $error("clocks run in sleep");
  chk_no_snoop_sleep: assert property (sleep_family |-> !snoop_irq_enable)
    else $error("snoops served while asleep");
  chk_reset_direct: assert property (sleep_family && reset_held |=> state == ST_NORMAL)
    else $error("reset did not leave sleep");
  chk_deep_from_sleep: assert property ($rose(state == ST_DEEP) |->
    $past(state) inside {ST_SLEEP, ST_DEEPER_EXIT}) else $error("deep sleep entered wrongly");
  chk_deeper_entry: assert property ($rose(state == ST_DEEPER) |-> $past(state) == ST_DEEP)
    else $error("deeper sleep entered wrongly");
  chk_deeper_vid: assert property (state == ST_DEEPER |-> voltage_id_code == `VID_DEEPER)
    else $error("deeper voltage code missing");
  chk_no_step_asleep: assert property (sleep_family |-> !step_start)
    else $error("transition started while asleep");
  chk_grant_bound: assert property (stop_grant_ack |-> ##[1:20] state == ST_STOP_GRANT)
    else $error("stop grant late");
  chk_deeper_req: assert property ((&core_idle_deepest)[*2] |-> deeper_request ##0
    $past(&core_idle_deepest)) else $error("deeper request wrong");
  chk_exit_restore: assert property ($rose(state == ST_DEEP) && $past(state) == ST_DEEPER_EXIT |->
    voltage_id_code == step_vid) else $error("deep voltage not restored");
  chk_therm_event: assert property ($changed(therm_active) |-> thermal_event)
    else $error("thermal transition without event");
  chk_cxe_lowest: assert property ($rose(state == ST_SG_ENTRY) && $past(state) == ST_CXE_DOWN |->
    cur_pstate == `LOWEST_PSTATE) else $error("stop grant above lowest point");

  cov_deeper_entry: cover property (state == ST_DEEP ##1 state == ST_DEEPER);
  cov_reset_in_sleep: cover property (sleep_family && reset_held);
  cov_thermal_cycle: cover property ($rose(therm_active) ##[1:1000] $fell(therm_active));
  cov_cxe_break: cover property (state == ST_CXE_DOWN ##1 state == ST_NORMAL);

endmodule : package_sleep_state_sequencer

// ===== tb/chipset_model.sv
// Chipset model driving the low power request pins in legal order
`timescale 1ns/1ps
module chipset_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] depth,
  input wire logic rst_req,
  output sleep_seq_pkg::lp_pins_s lp_pins
);
  logic [2:0] level;
  logic [9:0] hold;
  logic rst_n;
  // One pin per level, deepest last; nothing else on the bus moves
  assign lp_pins = {level < 3'h1, level < 3'h2, level < 3'h3, level < 3'h4, rst_n};
  // Spacing between steps; long hold for relock after deep release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level <= 3'h0;
      hold <= 10'h0;
      rst_n <= 1'h1;
    end
    else if (rst_req && rst_n)
      rst_n <= 1'h0;
    else if (rst_req)
      level <= 3'h0;
    else if (!rst_n)
      rst_n <= 1'h1;
    else if (hold != 10'h0)
      hold <= hold - 10'h1;
    else if (level != depth)
    begin
      level <= (level < depth) ? level + 3'h1 : level - 3'h1;
      hold <= (level == 3'h3 && depth < 3'h3) ? 10'h2F8 : 10'h28;
    end
  end
endmodule : chipset_model

// ===== tb/test_package_sleep_state_sequencer.sv
// Self-checking bench for the package sleep state sequencer
`timescale 1ns/1ps
module test_package_sleep_state_sequencer;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '1;
  logic s_axi_arvalid = '0, s_axi_rready = '1, die_hot = '0, rst_req = '0, bprev = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, core_idle_deepest = '0;
  logic [2:0] depth = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stop_grant_ack;
  logic internal_clock_enable, pll_keep_locked, snoop_irq_enable, block_next_request_n;
  logic deeper_request, thermal_event, core_reset;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  sleep_seq_pkg::vid_t voltage_id_code, ackv, bnrv;
  sleep_seq_pkg::lp_pins_s lp_pins;
  int errors = 0, compares = 0, tev = 0;
  package_sleep_state_sequencer #(.THERM_WAIT_CYCLES(20), .XFER_MAX_CYCLES(400)) dut_u (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .lp_pins, .die_hot, .core_idle_deepest, .stop_grant_ack,
    .internal_clock_enable, .pll_keep_locked, .snoop_irq_enable, .block_next_request_n, .voltage_id_code,
    .deeper_request, .thermal_event, .core_reset);
  chipset_model cs_u (.aclk, .aresetn, .depth, .rst_req, .lp_pins);
  // Free running bus clock, which the clock generator may keep in deep states
  initial forever #10 aclk = ~aclk;
  // Capture the voltage code at acknowledge and at relock start
  always @(posedge aclk)
  begin
    bprev <= block_next_request_n;
    if (stop_grant_ack === 1'b1) ackv <= voltage_id_code;
    if (bprev === 1'b1 && block_next_request_n === 1'b0) bnrv <= voltage_id_code;
    if (thermal_event === 1'b1) tev++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Requests hold until the rising edge that takes them; answers are taken at their own edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(negedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(negedge aclk);
  endtask : rd
  task automatic wst(input logic [2:0] s);
    for (int i = 0; i < 1500; i++)
    begin
      rd(8'h08);
      if (d[2:0] === s) break;
    end
    chk("state", s, d[2:0]);
  endtask : wst
  task automatic waitv(input logic [6:0] v);
    for (int i = 0; i < 3000 && voltage_id_code !== v; i++) @(negedge aclk);
    chk("vid", v, voltage_id_code);
  endtask : waitv
  task automatic wb(input logic v);
    for (int i = 0; i < 600 && block_next_request_n !== v; i++) @(negedge aclk);
    @(negedge aclk);
  endtask : wb
  task automatic t_reset;
    chk("vid", 7'h30, voltage_id_code);
    chk("bnr", 1'b1, block_next_request_n);
    rd(8'h00);
    chk("ctrl", 32'h1, d);
    rd(8'h04);
    chk("core", 32'h0, d);
    rd(8'h0C);
    chk("rresp", 2'h2, r);
    wr(8'h0C, 32'h5);
    chk("bresp", 2'h2, r);
    $display("reset test done");
  endtask : t_reset
  task automatic t_pstate;
    wr(8'h04, 32'h0000_0103);
    waitv(7'h24);
    wb(1'b0);
    chk("up order", 7'h24, bnrv);
    wb(1'b1);
    wr(8'h04, 32'h1);
    wb(1'b0);
    wr(8'h04, 32'h2);
    chk("down order", 7'h24, bnrv);
    waitv(7'h2C);
    waitv(7'h28);
    $display("pstate test done");
  endtask : t_pstate
  task automatic t_sleep;
    wr(8'h04, 32'h3);
    waitv(7'h24);
    depth <= 3'h1;
    wst(3'h3);
    chk("ack vid", 7'h30, ackv);
    depth <= 3'h2;
    wst(3'h4);
    chk("clk en", 1'b0, internal_clock_enable);
    chk("pll", 1'b1, pll_keep_locked);
    chk("snoop", 1'b0, snoop_irq_enable);
    wr(8'h04, 32'h2);
    repeat (30) @(negedge aclk);
    chk("frozen", 7'h30, voltage_id_code);
    depth <= 3'h4;
    wst(3'h6);
    chk("pll", 1'b0, pll_keep_locked);
    chk("vid", 7'h48, voltage_id_code);
    depth <= 3'h0;
    wst(3'h0);
    waitv(7'h28);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_thermal;
    @(posedge aclk) die_hot <= 1'b1;
    waitv(7'h30);
    @(posedge aclk) die_hot <= 1'b0;
    waitv(7'h28);
    chk("events", 2, tev);
    @(posedge aclk) core_idle_deepest <= 4'hF;
    repeat (3) @(negedge aclk);
    chk("deeper", 1'b1, deeper_request);
    @(posedge aclk) core_idle_deepest <= 4'h7;
    repeat (3) @(negedge aclk);
    chk("deeper", 1'b0, deeper_request);
    $display("thermal test done");
  endtask : t_thermal
  task automatic t_sysreset;
    depth <= 3'h1;
    wst(3'h3);
    depth <= 3'h2;
    wst(3'h4);
    rst_req <= 1'b1;
    for (int i = 0; i < 100 && core_reset !== 1'b1; i++) @(negedge aclk);
    chk("core rst", 1'b1, core_reset);
    chk("asleep", 1'b0, snoop_irq_enable);
    wst(3'h0);
    rst_req <= 1'b0;
    depth <= 3'h0;
    $display("system reset test done");
  endtask : t_sysreset
  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // Main sequence, reset held for three cycles
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_pstate();
    t_sleep();
    t_thermal();
    t_sysreset();
    complete_run();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #1200000;
    errors++;
    complete_run();
  end
endmodule : test_package_sleep_state_sequencer
